/* ftd_defines.svh */
`ifndef FTD_DEFINES_SVH
`define FTD_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FTD_MAP_BASE 16'hF380
`define FTD_MAP_LAST 16'hF3BF
`define FTD_CTRL_ADDR 16'hF3C0
`define FTD_STAT_ADDR 16'hF3C1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FTD_MAP_RST 16'h0000
`define FTD_CTRL_RST 2'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FTD_CTRL_HIZ_A 0
`define FTD_CTRL_HIZ_B 1
`define FTD_STAT_ACTIVE 0
`define FTD_STAT_SLOT_LSB 8
`define FTD_STAT_SLOT_MSB 12

// ----------------------------------------------------------------
// timing: bits per slot, slots per pin
// ----------------------------------------------------------------
`define FTD_SLOT_BITS 8
`define FTD_SLOTS_PER_PIN 32
`define FTD_WORD_BITS 32
`define FTD_NUM_CHANNELS 16

`endif

/* ftd_pkg.sv */
`default_nettype none

package ftd_pkg;

  // one slot map entry, 16 bits wide
  typedef struct packed {
    logic [7:0] rsvd;
    logic en;
    logic rev;
    logic grp;
    logic [2:0] ch;
    logic [1:0] bsel;
  } ftd_slot_map_t;

  // words of serial output channels 32..47, index 0 is channel 32
  typedef logic [15:0][31:0] ftd_words_t;

endpackage

`default_nettype wire

/* ftd_map_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftd_defines.svh"

// ----------------------------------------------------------------
// slot map storage: one write port, three registered read ports
// ----------------------------------------------------------------
module ftd_map_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 16,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic sw_rd,
  input wire logic [AW-1:0] sw_addr,
  input wire logic sw_bypass,
  input wire logic [WIDTH-1:0] sw_bypass_data,
  output logic [WIDTH-1:0] sw_q,
  input wire logic [AW-1:0] a_addr,
  output logic [WIDTH-1:0] a_q,
  input wire logic [AW-1:0] b_addr,
  output logic [WIDTH-1:0] b_q
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("ftd_map_mem: DEPTH must equal 2**AW");
  end

  // storage, cleared by reset so every slot starts disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= WIDTH'(`FTD_MAP_RST);
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // software read; stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_q <= '0;
    end else if (sw_rd) begin
      sw_q <= sw_bypass ? sw_bypass_data : mem_ff[sw_addr];
    end else begin
      sw_q <= '0;
    end
  end

  // slot lookups for the two pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= mem_ff[a_addr];
      b_q <= mem_ff[b_addr];
    end
  end

endmodule

`default_nettype wire

/* ftd_slot_source.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ftd_defines.svh"

module ftd_slot_source #(
  parameter int SLOT_BITS = `FTD_SLOT_BITS,
  parameter int SLOTS_PER_PIN = `FTD_SLOTS_PER_PIN,
  parameter int WORD_BITS = `FTD_WORD_BITS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic frame_start,
  input wire ftd_pkg::ftd_words_t chan_words,
  output logic flex_data_pin_a,
  output logic flex_data_pin_a_oe,
  output logic flex_data_pin_b,
  output logic flex_data_pin_b_oe
);
  import ftd_pkg::*;

  // the slot counter and byte picker are built for this geometry only
  if (SLOT_BITS != 8 || SLOTS_PER_PIN != 32 || WORD_BITS != 32) begin : g_bad_param
    $error("ftd_slot_source: only 8-bit slots, 32 slots per pin, 32-bit words");
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic in_map;
  logic [1:0] port_hiz_when_idle_ff;
  logic active_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [15:0] own_rdata;
  logic [15:0] map_a_raw;
  logic [15:0] map_b_raw;
  ftd_slot_map_t map_a;
  ftd_slot_map_t map_b;

  // the map window is 64 consecutive addresses
  assign in_map = (reg_addr >= `FTD_MAP_BASE) && (reg_addr <= `FTD_MAP_LAST);

  // own registers and unmapped addresses answer through the bypass
  always_comb begin
    own_rdata = 16'h0000;
    if (reg_addr == `FTD_CTRL_ADDR) begin
      own_rdata = {14'h0000, port_hiz_when_idle_ff};
    end else if (reg_addr == `FTD_STAT_ADDR) begin
      own_rdata[`FTD_STAT_ACTIVE] = active_ff;
      own_rdata[`FTD_STAT_SLOT_MSB:`FTD_STAT_SLOT_LSB] = cnt_ff[7:3];
    end else begin
      own_rdata = 16'h0000;
    end
  end

  // per-port idle drive choice
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_hiz_when_idle_ff <= `FTD_CTRL_RST;
    end else if (reg_wr && reg_addr == `FTD_CTRL_ADDR) begin
      port_hiz_when_idle_ff <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------------
  // one bit per clock; a frame start forces slot 0 bit 0
  assign nxt_cnt = frame_start ? 8'h00 : 8'(cnt_ff + 8'h01);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // pins stay idle until the first frame has been seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 1'b0;
    end else if (frame_start) begin
      active_ff <= 1'b1;
    end
  end

  // lookup is addressed by the next count so the entry lines up with cnt_ff
  ftd_map_mem #(
    .DEPTH(64),
    .WIDTH(16),
    .AW(6)
  ) u_map (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(reg_wr && in_map),
    .wr_addr(reg_addr[5:0]),
    .wr_data(reg_wdata),
    .sw_rd(reg_rd),
    .sw_addr(reg_addr[5:0]),
    .sw_bypass(!in_map),
    .sw_bypass_data(own_rdata),
    .sw_q(reg_rdata),
    .a_addr({1'b0, nxt_cnt[7:3]}),
    .a_q(map_a_raw),
    .b_addr({1'b1, nxt_cnt[7:3]}),
    .b_q(map_b_raw)
  );

  assign map_a = ftd_slot_map_t'(map_a_raw);
  assign map_b = ftd_slot_map_t'(map_b_raw);

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick_byte(input logic [31:0] word, input logic [1:0] bsel);
    logic [7:0] r;
    r = 8'h00;
    case (bsel)
      2'b00: r = word[31:24];
      2'b01: r = word[23:16];
      2'b10: r = word[15:8];
      default: r = word[7:0];
    endcase
    return r;
  endfunction

  logic [3:0] idx_a;
  logic [3:0] idx_b;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic [7:0] byte_a;
  logic [7:0] byte_b;
  logic bit_a;
  logic bit_b;

  // group bit is the high index bit: base 32 or 40, code adds on top
  assign idx_a = {map_a.grp, map_a.ch};
  assign idx_b = {map_b.grp, map_b.ch};
  assign word_a = chan_words[idx_a];
  assign word_b = chan_words[idx_b];
  assign byte_a = pick_byte(word_a, map_a.bsel);
  assign byte_b = pick_byte(word_b, map_b.bsel);
  // msb first unless reversed; ~cnt is 7 minus the bit position
  assign bit_a = map_a.rev ? byte_a[cnt_ff[2:0]] : byte_a[~cnt_ff[2:0]];
  assign bit_b = map_b.rev ? byte_b[cnt_ff[2:0]] : byte_b[~cnt_ff[2:0]];

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // pins lag the counter by one cycle; disabled slot is low or released
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flex_data_pin_a <= 1'b0;
      flex_data_pin_a_oe <= 1'b0;
      flex_data_pin_b <= 1'b0;
      flex_data_pin_b_oe <= 1'b0;
    end else begin
      flex_data_pin_a <= active_ff && map_a.en && bit_a;
      flex_data_pin_a_oe <= (active_ff && map_a.en) || !port_hiz_when_idle_ff[`FTD_CTRL_HIZ_A];
      flex_data_pin_b <= active_ff && map_b.en && bit_b;
      flex_data_pin_b_oe <= (active_ff && map_b.en) || !port_hiz_when_idle_ff[`FTD_CTRL_HIZ_B];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // reference bit taken from the flat word vector by arithmetic
  logic [511:0] words_flat;
  int exp_pos_a;
  int exp_pos_b;
  logic exp_bit_a;
  logic exp_bit_b;

  assign words_flat = chan_words;
  assign exp_pos_a = int'(idx_a) * 32 + (map_a.rev ? 24 + int'(cnt_ff[2:0]) : 31 - int'(cnt_ff[2:0]))
                     - 8 * int'(map_a.bsel);
  assign exp_pos_b = int'(idx_b) * 32 + (map_b.rev ? 24 + int'(cnt_ff[2:0]) : 31 - int'(cnt_ff[2:0]))
                     - 8 * int'(map_b.bsel);
  assign exp_bit_a = words_flat[exp_pos_a];
  assign exp_bit_b = words_flat[exp_pos_b];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_group_low: assert property (active_ff && map_a.en && !map_a.grp |=> flex_data_pin_a == $past(exp_bit_a))
    else $error("group 0 slot on pin a sent wrong bit");
  a_group_high: assert property (active_ff && map_b.en && map_b.grp |=> flex_data_pin_b == $past(exp_bit_b))
    else $error("group 1 slot on pin b sent wrong bit");
  a_chan_offset: assert property (word_a == words_flat[(int'(map_a.grp) * 8 + int'(map_a.ch)) * 32 +: 32])
    else $error("selected word is not group base plus code");
  a_byte_lane: assert property (active_ff && map_a.en && !map_a.rev && map_a.bsel == 2'b00
                                |=> flex_data_pin_a == $past(word_a[31 - int'(cnt_ff[2:0])]))
    else $error("byte 0 did not come from bits 31 to 24");
  a_word_bytes: assert property (byte_b == 8'(word_b >> (24 - 8 * int'(map_b.bsel))))
    else $error("selected byte not a lane of the 32-bit word");
  a_pin_split: assert property (frame_start |=> cnt_ff == 8'h00 && map_a_raw == $past(u_map.mem_ff[0])
                                && map_b_raw == $past(u_map.mem_ff[32]))
    else $error("slot 0 and slot 32 entries not on pins a and b");
  a_idle_drive: assert property (active_ff && !map_a.en
                                 |=> !flex_data_pin_a && flex_data_pin_a_oe == !$past(port_hiz_when_idle_ff[0]))
    else $error("disabled slot drove pin a wrongly");
  a_reverse_order: assert property (active_ff && map_b.en && map_b.rev
                                    |=> flex_data_pin_b == $past(byte_b[cnt_ff[2:0]]))
    else $error("reversed slot not sent lsb first");
  a_read_once: assert property (reg_rd |=> ##1 (reg_rdata == 16'h0000 || $past(reg_rd)))
    else $error("read data stood past its cycle");

  c_reversed_slot: cover property (active_ff && map_a.en && map_a.rev);
  c_group_high_b: cover property (active_ff && map_b.en && map_b.grp && map_b.bsel == 2'b11);
  c_hiz_idle: cover property (active_ff && !map_a.en && !flex_data_pin_a_oe);
  c_frame_wrap: cover property (cnt_ff == 8'hFF ##1 cnt_ff == 8'h00);

endmodule

`default_nettype wire

/* ftd_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// receiving tdm device on one flexible data pin
// ----------------------------------------------------------------
module ftd_rx_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  input wire logic oe,
  output logic line,
  output logic [7:0] rx_byte_ff,
  output logic [7:0] rx_drv_ff
);
  logic last_ff;

  // released wire shows the inverse of its last level, never a stale copy
  assign line = oe ? pin : ~last_ff;

  // shift in one bit per clock, first bit of a slot ends on top
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
      rx_drv_ff <= 8'h00;
    end else begin
      last_ff <= line;
      rx_byte_ff <= {rx_byte_ff[6:0], line};
      rx_drv_ff <= {rx_drv_ff[6:0], oe};
    end
  end
endmodule

`default_nettype wire

/* tb_flex_tdm_out_slot_source_select.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// bench for slot source selection
// ----------------------------------------------------------------
module tb_flex_tdm_out_slot_source_select;
  import ftd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic frame_start = 1'b0;
  logic [15:0] reg_rdata;
  ftd_words_t chan_words = '0;
  logic pin_a, oe_a, pin_b, oe_b, line_a, line_b;
  logic [7:0] byte_a, drv_a, byte_b, drv_b;
  logic [15:0] d;
  int err_total = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  ftd_slot_source uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .chan_words(chan_words), .flex_data_pin_a(pin_a), .flex_data_pin_a_oe(oe_a),
    .flex_data_pin_b(pin_b), .flex_data_pin_b_oe(oe_b));
  ftd_rx_model rx_a (.clk(clk), .reset_n(reset_n), .pin(pin_a), .oe(oe_a), .line(line_a),
    .rx_byte_ff(byte_a), .rx_drv_ff(drv_a));
  ftd_rx_model rx_b (.clk(clk), .reset_n(reset_n), .pin(pin_b), .oe(oe_b), .line(line_b),
    .rx_byte_ff(byte_b), .rx_drv_ff(drv_b));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // stride 5 visits all 16 channels; pin b flips group and reverse so a pin swap shows
  // slot 16 of each pin is disabled
  function automatic ftd_slot_map_t ent(input int n);
    ftd_slot_map_t e;
    logic [3:0] idx;
    idx = 4'((n * 5 + 3 + 8 * (n / 32)) % 16);
    e.rsvd = 8'(n);
    e.en = (n % 32) != 16;
    e.rev = n[2] ^ n[0] ^ n[5];
    e.grp = idx[3];
    e.ch = idx[2:0];
    e.bsel = n[1:0] ^ n[3:2];
    return e;
  endfunction

  function automatic logic [7:0] expb(input ftd_slot_map_t e);
    logic [7:0] b;
    b = chan_words[{e.grp, e.ch}][8 * (3 - e.bsel) +: 8];
    if (e.rev) b = {<<{b}};
    return b;
  endfunction

  // one frame: the model holds slot s after edge start+9+8s
  task automatic run_frame(input logic [1:0] hiz);
    wr(16'hF3C0, {14'h0000, hiz});
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (9) @(posedge clk);
    for (int s = 0; s < 17; s++) begin
      #1;
      if (s < 16) begin
        chk({byte_a, drv_a}, {expb(ent(s)), 8'hFF});
        chk({byte_b, drv_b}, {expb(ent(32 + s)), 8'hFF});
      end else begin
        chk({hiz[0] ? 8'h00 : byte_a, drv_a}, hiz[0] ? 16'h0000 : 16'h00FF);
        chk({hiz[1] ? 8'h00 : byte_b, drv_b}, hiz[1] ? 16'h0000 : 16'h00FF);
      end
      repeat (8) @(posedge clk);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog, well beyond two frames plus register traffic
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      chan_words[i] <= {4'hA, 4'(i), 4'h5, 4'(i), 4'hC, 4'(i), 4'h3, 4'(i)};
    end
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk({12'h000, pin_a, oe_a, pin_b, oe_b}, 16'h0005);
    rd(16'hF380, d);
    chk(d, 16'h0000);
    rd(16'hF3FF, d);
    chk(d, 16'h0000);
    for (int n = 0; n < 17; n++) begin
      wr(16'hF380 + 16'(n), ent(n));
      wr(16'hF3A0 + 16'(n), ent(32 + n));
    end
    for (int n = 0; n < 17; n++) begin
      rd(16'hF3A0 + 16'(n), d);
      chk(d, ent(32 + n));
    end
    run_frame(2'b01);
    // restart in mid-frame with the idle modes swapped
    run_frame(2'b10);
    wr(16'hF3C1, 16'h0000);
    rd(16'hF3C1, d);
    chk(d & 16'h0001, 16'h0001);
    rd(16'hF3C0, d);
    chk(d, 16'h0002);
    summarize();
  end
endmodule

`default_nettype wire
